// ===== core/ffb_engine.sv
// Free function block engine: polyline, pulse stretcher, first-order lag,
// reset-dominant latch, saturating subtracter, four-input parity gate.
// Assumes an Avalon-MM master on clk and phys_in driven by logic on clk.
//
// Contract
// (R1) Polyline maps X through 20 interpolated points
// (R2) Polyline output flat beyond end points
// (R3) Host writes abscissas strictly ascending
// (R4) Host fills unused points with last point
// (R5) Stretcher: rise sets, clears after T, input low
// (R6) Stretcher reset input forces output low
// (R7) Lag follows input with time constant T
// (R8) Lag set input loads preset value
// (R9) Latch holds, sets, reset dominates
// (R10) Subtracter gives X0 minus X1, saturated
// (R11) Parity gate high for odd inputs
// (R12) Physical inputs normalised to reference
// (R13) Outputs rescaled by reference to physical
// (R14) Host enters limits as normalised values
// (R15) Blocks inactive until assigned to group
// (R16) Blocks run in ascending sequence order
// (R17) Recompute once per group cycle
`timescale 1ns/1ps
`default_nettype none

module ffb_engine
  import ffb_pkg::*;
#(
  parameter int GROUP1_PERIOD = GROUP1_CYCLES,
  parameter int GROUP2_PERIOD = GROUP2_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] phys_in,
  output logic [31:0] poly_y,
  output logic pulse_q,
  output logic [31:0] lag_y,
  output logic latch_q,
  output logic inverted_output,
  output logic [31:0] sub_y,
  output logic xor_q,
  output logic [31:0] phys_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [12:0] group;
    logic [23:0] seq;
    logic [31:0] poly_x;
    logic [31:0] pst_t;
    logic [4:0] lag_k;
    logic [31:0] lag_x;
    logic [31:0] lag_pre;
    logic [8:0] bits;
    logic [31:0] sub_x0;
    logic [31:0] sub_x1;
    logic [31:0] refv;
    logic [NPOINTS-1:0][31:0] pa;
    logic [NPOINTS-1:0][31:0] pb;
    logic [31:0] poly_y;
    logic [31:0] pst_cnt;
    logic pst_q;
    logic pst_prev;
    logic [31:0] lag_y;
    logic lat_q;
    logic [31:0] sub_y;
    logic xor_q;
    logic [31:0] phys_out;
    logic [31:0] div1;
    logic [31:0] div2;
    logic [1:0] pend;
    logic run;
    logic [1:0] grp;
    logic [3:0] step;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic [NBLOCKS-1:0] eval;
  logic [4:0] seg;
  logic signed [32:0] dx;
  logic signed [32:0] dy;
  logic signed [32:0] dd;
  logic signed [65:0] prod;
  logic signed [65:0] quot;
  logic [31:0] poly_calc;
  logic signed [47:0] norm_num;
  logic [31:0] norm_x;
  logic [31:0] x_sel;
  logic signed [63:0] phys_prod;
  logic signed [32:0] sub_diff;
  logic signed [32:0] lag_diff;
  logic signed [32:0] lag_step;
  logic [8:0] wofs;
  logic [4:0] pidx;
  logic [31:0] wmerged;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ---------------------------------------------------------------
  // Datapath helpers
  // ---------------------------------------------------------------
  // Block selected when its group matches the running group and step
  always_comb begin
    for (int b = 0; b < NBLOCKS; b++) begin
      eval[b] = s_reg.run && s_reg.group[b*2 +: 2] == s_reg.grp
                && s_reg.seq[b*4 +: 4] == s_reg.step; // R15 R16
    end
  end

  // Normalisation; a zero reference yields zero instead of a divide fault
  always_comb begin
    norm_num = {$signed(phys_in), 16'h0000};
    if (s_reg.refv == 32'h0000_0000) begin
      norm_x = 32'h0000_0000;
    end else begin
      norm_x = 32'(norm_num / $signed(s_reg.refv)); // R12
    end
    x_sel = s_reg.group[GROUP_POLY_SRC_BIT] ? norm_x : s_reg.poly_x;
    phys_prod = $signed(s_reg.poly_y) * $signed(s_reg.refv);
  end

  // Polyline: pick the last segment start not above X, then interpolate.
  // Relies on ascending abscissas; equal padding points act as a flat tail.
  always_comb begin
    seg = 5'h00;
    for (int i = 1; i < NPOINTS; i++) begin
      if ($signed(x_sel) >= $signed(s_reg.pa[i])) begin
        seg = 5'(i); // R3 R4
      end
    end
    dx = 33'($signed(x_sel)) - 33'($signed(s_reg.pa[seg]));
    dy = 33'sh0;
    dd = 33'sh1;
    if (seg < 5'(NPOINTS - 1)) begin
      dy = 33'($signed(s_reg.pb[seg + 5'h01])) - 33'($signed(s_reg.pb[seg]));
      dd = 33'($signed(s_reg.pa[seg + 5'h01])) - 33'($signed(s_reg.pa[seg]));
    end
    prod = 66'(dx) * 66'(dy);
    quot = (dd == 33'sh0) ? 66'sh0 : prod / 66'(dd);
    if ($signed(x_sel) <= $signed(s_reg.pa[0])) begin
      poly_calc = s_reg.pb[0]; // R2
    end else if (seg == 5'(NPOINTS - 1)) begin
      poly_calc = s_reg.pb[NPOINTS-1]; // R2
    end else begin
      poly_calc = s_reg.pb[seg] + quot[31:0]; // R1
    end
  end

  // Subtracter and lag arithmetic at one bit of headroom
  always_comb begin
    sub_diff = 33'($signed(s_reg.sub_x0)) - 33'($signed(s_reg.sub_x1));
    lag_diff = 33'($signed(s_reg.lag_x)) - 33'($signed(s_reg.lag_y));
    lag_step = lag_diff >>> s_reg.lag_k;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    wofs = avs_address;
    pidx = 5'(avs_address[8:2] - 7'h20);
    wmerged = 32'h0000_0000;

    // Runtime group dividers; a tick is held pending until served
    s_next.div1 = (s_reg.div1 == 32'(GROUP1_PERIOD - 1)) ? 32'h0 : s_reg.div1 + 32'h1;
    s_next.div2 = (s_reg.div2 == 32'(GROUP2_PERIOD - 1)) ? 32'h0 : s_reg.div2 + 32'h1;
    if (s_reg.div1 == 32'(GROUP1_PERIOD - 1)) begin
      s_next.pend[0] = 1'b1; // R17
    end
    if (s_reg.div2 == 32'(GROUP2_PERIOD - 1)) begin
      s_next.pend[1] = 1'b1; // R17
    end

    // Sequencer walks steps 0..15 once per group cycle
    if (s_reg.run) begin
      if (s_reg.step == 4'hF) begin
        s_next.run = 1'b0;
      end
      s_next.step = s_reg.step + 4'h1; // R16
    end else if (s_reg.pend[0]) begin
      s_next.run = 1'b1;
      s_next.grp = 2'h1;
      s_next.step = 4'h0;
      s_next.pend[0] = s_next.pend[0] && s_reg.div1 == 32'(GROUP1_PERIOD - 1);
    end else if (s_reg.pend[1]) begin
      s_next.run = 1'b1;
      s_next.grp = 2'h2;
      s_next.step = 4'h0;
      s_next.pend[1] = s_next.pend[1] && s_reg.div2 == 32'(GROUP2_PERIOD - 1);
    end

    // Block evaluations
    if (eval[BLK_POLY]) begin
      s_next.poly_y = poly_calc; // R1
    end
    if (eval[BLK_PST]) begin
      s_next.pst_prev = s_reg.bits[BIT_PST_IN];
      if (s_reg.bits[BIT_PST_RST]) begin
        s_next.pst_q = 1'b0; // R6
        s_next.pst_cnt = 32'h0;
      end else if (s_reg.bits[BIT_PST_IN] && !s_reg.pst_prev) begin
        s_next.pst_q = 1'b1; // R5
        s_next.pst_cnt = s_reg.pst_t;
      end else begin
        if (s_reg.pst_cnt != 32'h0) begin
          s_next.pst_cnt = s_reg.pst_cnt - 32'h1; // R17
        end
        if (!s_reg.bits[BIT_PST_IN] && s_reg.pst_cnt <= 32'h1) begin
          s_next.pst_q = 1'b0; // R5
        end
      end
    end
    if (eval[BLK_LAG]) begin
      if (s_reg.bits[BIT_LAG_SET]) begin
        s_next.lag_y = s_reg.lag_pre; // R8
      end else begin
        s_next.lag_y = s_reg.lag_y + lag_step[31:0]; // R7
      end
    end
    if (eval[BLK_LATCH]) begin
      if (s_reg.bits[BIT_LAT_R]) begin
        s_next.lat_q = 1'b0; // R9
      end else if (s_reg.bits[BIT_LAT_S]) begin
        s_next.lat_q = 1'b1; // R9
      end
    end
    if (eval[BLK_SUB]) begin
      if (sub_diff > 33'sh0_7FFF_FFFF) begin
        s_next.sub_y = SAT_MAX; // R10
      end else if (sub_diff < -33'sh0_8000_0000) begin
        s_next.sub_y = SAT_MIN; // R10
      end else begin
        s_next.sub_y = sub_diff[31:0]; // R10
      end
    end
    if (eval[BLK_XOR]) begin
      s_next.xor_q = ^s_reg.bits[BIT_XOR_I0 +: 4]; // R11
    end

    // Rescale the polyline output back to a physical value
    s_next.phys_out = phys_prod[47:16]; // R13

    // Bus slave: one wait cycle, then the access completes
    s_next.ack = (avs_read || avs_write) && !s_reg.ack;
    if (avs_read && !s_reg.ack) begin
      case (wofs)
        OFS_GROUP: s_next.rdata = {19'h0, s_reg.group};
        OFS_SEQ: s_next.rdata = {8'h00, s_reg.seq};
        OFS_POLY_X: s_next.rdata = s_reg.poly_x;
        OFS_PST_T: s_next.rdata = s_reg.pst_t;
        OFS_LAG_K: s_next.rdata = {27'h0, s_reg.lag_k};
        OFS_LAG_X: s_next.rdata = s_reg.lag_x;
        OFS_LAG_PRE: s_next.rdata = s_reg.lag_pre;
        OFS_BITS: s_next.rdata = {23'h0, s_reg.bits};
        OFS_SUB_X0: s_next.rdata = s_reg.sub_x0;
        OFS_SUB_X1: s_next.rdata = s_reg.sub_x1;
        OFS_REF: s_next.rdata = s_reg.refv;
        OFS_STATUS: s_next.rdata = {27'h0, s_reg.run, s_reg.xor_q, !s_reg.lat_q,
                                    s_reg.lat_q, s_reg.pst_q};
        OFS_POLY_Y: s_next.rdata = s_reg.poly_y;
        OFS_LAG_Y: s_next.rdata = s_reg.lag_y;
        OFS_SUB_Y: s_next.rdata = s_reg.sub_y;
        OFS_PHYS_OUT: s_next.rdata = s_reg.phys_out;
        default: begin
          s_next.rdata = 32'h0000_0000;
          // Upper bound keeps the wrapped index of the B window from aliasing the A table
          if (wofs >= OFS_A_BASE && wofs < OFS_B_BASE && pidx < 5'(NPOINTS)) begin
            s_next.rdata = s_reg.pa[pidx];
          end else if (wofs >= OFS_B_BASE) begin
            if (5'(avs_address[8:2] - 7'h40) < 5'(NPOINTS)
                && avs_address[8:2] < 7'h54) begin
              s_next.rdata = s_reg.pb[5'(avs_address[8:2] - 7'h40)];
            end
          end
        end
      endcase
    end
    // Writes take effect at the edge where waitrequest is low
    if (avs_write && s_reg.ack) begin
      case (wofs)
        OFS_GROUP: begin
          wmerged = merge({19'h0, s_reg.group}, avs_writedata, avs_byteenable);
          s_next.group = wmerged[12:0]; // R15
        end
        OFS_SEQ: begin
          wmerged = merge({8'h00, s_reg.seq}, avs_writedata, avs_byteenable);
          s_next.seq = wmerged[23:0]; // R16
        end
        OFS_POLY_X: s_next.poly_x = merge(s_reg.poly_x, avs_writedata, avs_byteenable);
        OFS_PST_T: s_next.pst_t = merge(s_reg.pst_t, avs_writedata, avs_byteenable);
        OFS_LAG_K: begin
          wmerged = merge({27'h0, s_reg.lag_k}, avs_writedata, avs_byteenable);
          s_next.lag_k = wmerged[4:0];
        end
        OFS_LAG_X: s_next.lag_x = merge(s_reg.lag_x, avs_writedata, avs_byteenable);
        OFS_LAG_PRE: s_next.lag_pre = merge(s_reg.lag_pre, avs_writedata, avs_byteenable);
        OFS_BITS: begin
          wmerged = merge({23'h0, s_reg.bits}, avs_writedata, avs_byteenable);
          s_next.bits = wmerged[8:0];
        end
        OFS_SUB_X0: s_next.sub_x0 = merge(s_reg.sub_x0, avs_writedata, avs_byteenable);
        OFS_SUB_X1: s_next.sub_x1 = merge(s_reg.sub_x1, avs_writedata, avs_byteenable);
        OFS_REF: s_next.refv = merge(s_reg.refv, avs_writedata, avs_byteenable);
        default: begin
          if (wofs >= OFS_A_BASE && wofs < OFS_B_BASE && pidx < 5'(NPOINTS)) begin
            s_next.pa[pidx] = merge(s_reg.pa[pidx], avs_writedata, avs_byteenable);
          end else if (wofs >= OFS_B_BASE && avs_address[8:2] < 7'h54) begin
            s_next.pb[5'(avs_address[8:2] - 7'h40)] =
              merge(s_reg.pb[5'(avs_address[8:2] - 7'h40)], avs_writedata, avs_byteenable);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register stage; every block starts unassigned and idle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.refv <= REF_RESET;
      s_reg.lag_k <= LAG_K_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state; waitrequest also decodes the read and write requests
  assign avs_waitrequest = (avs_read || avs_write) && !s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign poly_y = s_reg.poly_y;
  assign pulse_q = s_reg.pst_q;
  assign lag_y = s_reg.lag_y;
  assign latch_q = s_reg.lat_q;
  assign inverted_output = !s_reg.lat_q;
  assign sub_y = s_reg.sub_y;
  assign xor_q = s_reg.xor_q;
  assign phys_out = s_reg.phys_out;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence pst_rise_seq;
    eval[BLK_PST] && !s_reg.bits[BIT_PST_RST] && s_reg.bits[BIT_PST_IN] && !s_reg.pst_prev;
  endsequence
  sequence run_start_seq;
    !s_reg.run ##1 s_reg.run;
  endsequence

  AST_PST_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    pst_rise_seq |=> pulse_q) else $error("stretcher did not set on rising input"); // R5
  AST_PST_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    eval[BLK_PST] && s_reg.bits[BIT_PST_RST] |=> !pulse_q)
    else $error("stretcher reset did not clear output"); // R6
  AST_LAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    eval[BLK_LAG] && s_reg.bits[BIT_LAG_SET] |=> lag_y == $past(s_reg.lag_pre))
    else $error("lag output not loaded with preset"); // R8
  AST_LATCH_RDOM: assert property (@(posedge clk) disable iff (!rst_n)
    eval[BLK_LATCH] && s_reg.bits[BIT_LAT_R] |=> !latch_q && inverted_output)
    else $error("latch reset did not dominate"); // R9
  AST_SUB_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    eval[BLK_SUB] && sub_diff > 33'sh0_7FFF_FFFF |=> sub_y == SAT_MAX)
    else $error("subtracter did not saturate high"); // R10
  AST_XOR_PAR: assert property (@(posedge clk) disable iff (!rst_n)
    eval[BLK_XOR] |=> xor_q == ^$past(s_reg.bits[BIT_XOR_I0 +: 4]))
    else $error("parity output wrong"); // R11
  AST_INACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.group[BLK_SUB*2 +: 2] == 2'h0 && !avs_write |=> $stable(sub_y))
    else $error("unassigned block changed output"); // R15
  AST_SEQ_WALK: assert property (@(posedge clk) disable iff (!rst_n)
    run_start_seq |-> s_reg.step == 4'h0 ##15 s_reg.run && s_reg.step == 4'hF ##1 !s_reg.run)
    else $error("sequence walk not 16 ascending steps"); // R16 R17

endmodule : ffb_engine

`default_nettype wire

// ===== pkg/ffb_pkg.sv
// Constants shared by the free function block engine and its bench.
// Assumes one 50 MHz clock; values are signed Q16.16 fixed point.
package ffb_pkg;

  // ---------------------------------------------------------------
  // Clock and runtime group timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int GROUP1_TIME_US = 1000;
  localparam int GROUP2_TIME_US = 8000;
  localparam int GROUP1_CYCLES = GROUP1_TIME_US * (CLK_HZ / 1_000_000);
  localparam int GROUP2_CYCLES = GROUP2_TIME_US * (CLK_HZ / 1_000_000);

  // ---------------------------------------------------------------
  // Number format and block layout
  // ---------------------------------------------------------------
  localparam int FRAC_BITS = 16;
  localparam int NPOINTS = 20;
  localparam int NBLOCKS = 6;
  localparam int BLK_POLY = 0;
  localparam int BLK_PST = 1;
  localparam int BLK_LAG = 2;
  localparam int BLK_LATCH = 3;
  localparam int BLK_SUB = 4;
  localparam int BLK_XOR = 5;
  localparam logic [31:0] SAT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_MIN = 32'h8000_0000;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [8:0] OFS_GROUP = 9'h000;
  localparam logic [8:0] OFS_SEQ = 9'h004;
  localparam logic [8:0] OFS_POLY_X = 9'h008;
  localparam logic [8:0] OFS_PST_T = 9'h00C;
  localparam logic [8:0] OFS_LAG_K = 9'h010;
  localparam logic [8:0] OFS_LAG_X = 9'h014;
  localparam logic [8:0] OFS_LAG_PRE = 9'h018;
  localparam logic [8:0] OFS_BITS = 9'h01C;
  localparam logic [8:0] OFS_SUB_X0 = 9'h020;
  localparam logic [8:0] OFS_SUB_X1 = 9'h024;
  localparam logic [8:0] OFS_REF = 9'h028;
  localparam logic [8:0] OFS_STATUS = 9'h02C;
  localparam logic [8:0] OFS_POLY_Y = 9'h030;
  localparam logic [8:0] OFS_LAG_Y = 9'h034;
  localparam logic [8:0] OFS_SUB_Y = 9'h038;
  localparam logic [8:0] OFS_PHYS_OUT = 9'h03C;
  localparam logic [8:0] OFS_A_BASE = 9'h080;
  localparam logic [8:0] OFS_B_BASE = 9'h100;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GROUP_POLY_SRC_BIT = 12; // Polyline X from normalised input
  localparam int BIT_PST_IN = 0;
  localparam int BIT_PST_RST = 1;
  localparam int BIT_LAG_SET = 2;
  localparam int BIT_LAT_S = 3;
  localparam int BIT_LAT_R = 4;
  localparam int BIT_XOR_I0 = 5;
  localparam int ST_PST_Q = 0;
  localparam int ST_LAT_Q = 1;
  localparam int ST_LAT_QN = 2;
  localparam int ST_XOR_Q = 3;
  localparam int ST_BUSY = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] REF_RESET = 32'h0001_0000;
  localparam logic [4:0] LAG_K_RESET = 5'h04;

endpackage : ffb_pkg

// ===== sim/tb.sv
// Self-checking bench for the free function block engine.
// Assumes the engine's Avalon-MM slave on clk; short group periods, group 2 a multiple
// of group 1 so that its run never shifts a group 1 evaluation.
`timescale 1ns/1ps
`default_nettype none

module tb
  import ffb_pkg::*;
;
  localparam int G1 = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] phys_in = 32'h0;
  logic [31:0] poly_y, lag_y, sub_y, phys_out;
  logic pulse_q, latch_q, inverted_output, xor_q;
  logic [31:0] bits_val = 32'h0;
  logic [31:0] rd;
  int err_count = 0;
  int check_count = 0;

  // -------------------------------------------------------------
  // Clock, design and shared tasks
  // -------------------------------------------------------------
  always #10 clk = ~clk;

  ffb_engine #(.GROUP1_PERIOD(G1), .GROUP2_PERIOD(200)) dut_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phys_in(phys_in),
    .poly_y(poly_y), .pulse_q(pulse_q), .lag_y(lag_y), .latch_q(latch_q),
    .inverted_output(inverted_output), .sub_y(sub_y), .xor_q(xor_q), .phys_out(phys_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low at a rising edge; the sample is taken
  // in the low half so it is the settled value that edge sees, not a racing update
  task automatic bus(input logic [8:0] a, input logic wr, input logic [31:0] d);
    logic wait_seen;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    wait_seen = 1'b1;
    while (wait_seen) begin
      @(negedge clk);
      wait_seen = (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      @(posedge clk);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic groups(input int n);
    repeat (n * G1) @(posedge clk);
    @(negedge clk);
  endtask : groups

  task automatic set_bits(input int pos, input logic v);
    bits_val[pos] = v;
    bus(OFS_BITS, 1'b1, bits_val);
    groups(2);
  endtask : set_bits

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Reset values, unmapped place, and blocks idle before group assignment
  task automatic test_reset_idle;
    bus(OFS_REF, 1'b0, 32'h0);
    check(rd, REF_RESET, "ref reset");
    bus(OFS_LAG_K, 1'b0, 32'h0);
    check(rd, 32'(LAG_K_RESET), "lag_k reset");
    bus(9'h044, 1'b1, 32'hA5A5_A5A5);
    bus(9'h044, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(OFS_SUB_X0, 1'b1, 32'h0005_0000);
    set_bits(BIT_LAT_S, 1'b1);
    groups(2);
    check(sub_y, 32'h0, "sub idle");
    check(latch_q, 1'b0, "latch idle");
    set_bits(BIT_LAT_S, 1'b0);
    bus(OFS_SEQ, 1'b1, 32'h0054_3210);
    bus(OFS_GROUP, 1'b1, 32'h0000_0555);
    groups(2);
    check(sub_y, 32'h0005_0000, "sub active");
    $display("test reset_idle done");
  endtask : test_reset_idle

  // Polyline: A_i = i, B_i = 1 + 2i, inside and both ends, then from phys_in
  task automatic test_poly;
    logic [31:0] xs[3] = '{32'hFFFF_0000, 32'h0002_8000, 32'h001E_0000};
    logic [31:0] ys[3] = '{32'h0001_0000, 32'h0006_0000, 32'h0027_0000};
    for (int i = 0; i < NPOINTS; i++) begin
      bus(9'(OFS_A_BASE + 9'(i * 4)), 1'b1, 32'(i) << 16);
      bus(9'(OFS_B_BASE + 9'(i * 4)), 1'b1, 32'h0001_0000 + (32'(i) << 17));
    end
    bus(9'(OFS_B_BASE + 9'h008), 1'b0, 32'h0);
    check(rd, 32'h0005_0000, "point B2 readback");
    for (int i = 0; i < 3; i++) begin
      bus(OFS_POLY_X, 1'b1, xs[i]);
      groups(2);
      check(poly_y, ys[i], "poly y");
    end
    bus(OFS_REF, 1'b1, 32'h0002_0000);
    phys_in <= 32'h0005_0000;
    bus(OFS_GROUP, 1'b1, 32'h0000_1555);
    groups(2);
    check(poly_y, 32'h0006_0000, "poly from normalised input");
    check(phys_out, 32'h000C_0000, "physical output");
    bus(OFS_POLY_Y, 1'b0, 32'h0);
    check(rd, 32'h0006_0000, "poly y register");
    $display("test poly done");
  endtask : test_poly

  // Stretcher with T = 6 group cycles, then reset over a high input
  task automatic test_pst;
    bus(OFS_PST_T, 1'b1, 32'd6);
    set_bits(BIT_PST_IN, 1'b1);
    check(pulse_q, 1'b1, "pst rise");
    set_bits(BIT_PST_IN, 1'b0);
    check(pulse_q, 1'b1, "pst stretched");
    groups(6);
    check(pulse_q, 1'b0, "pst expired");
    set_bits(BIT_PST_IN, 1'b1);
    check(pulse_q, 1'b1, "pst second rise");
    set_bits(BIT_PST_RST, 1'b1);
    check(pulse_q, 1'b0, "pst reset");
    set_bits(BIT_PST_IN, 1'b0);
    set_bits(BIT_PST_RST, 1'b0);
    $display("test pst done");
  endtask : test_pst

  // Lag: preset load, then step from 2.0 towards 4.0 with T = 4 cycles
  task automatic test_lag;
    bus(OFS_LAG_K, 1'b1, 32'd2);
    bus(OFS_LAG_PRE, 1'b1, 32'h0002_0000);
    bus(OFS_LAG_X, 1'b1, 32'h0004_0000);
    set_bits(BIT_LAG_SET, 1'b1);
    check(lag_y, 32'h0002_0000, "lag preset");
    set_bits(BIT_LAG_SET, 1'b0);
    check(lag_y > 32'h0002_0000 && lag_y < 32'h0004_0000, 1'b1, "lag rising");
    groups(30);
    check(lag_y >= 32'h0003_F000 && lag_y <= 32'h0004_0000, 1'b1, "lag settled");
    $display("test lag done");
  endtask : test_lag

  // Latch: set, hold, both, hold, reset, set, reset
  task automatic test_latch;
    logic [1:0] sr[7] = '{2'b10, 2'b00, 2'b11, 2'b00, 2'b01, 2'b10, 2'b01};
    logic q_exp[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      bits_val[BIT_LAT_S] = sr[i][1];
      set_bits(BIT_LAT_R, sr[i][0]);
      check(latch_q, q_exp[i], "latch q");
      check(inverted_output, !q_exp[i], "latch inverted");
    end
    $display("test latch done");
  endtask : test_latch

  // Subtracter: plain, positive overflow, negative overflow
  task automatic test_sub;
    logic [31:0] a[3] = '{32'h0005_0000, 32'h7000_0000, 32'h9000_0000};
    logic [31:0] b[3] = '{32'h0002_0000, 32'h9000_0000, 32'h7000_0000};
    logic [31:0] e[3] = '{32'h0003_0000, SAT_MAX, SAT_MIN};
    for (int i = 0; i < 3; i++) begin
      bus(OFS_SUB_X0, 1'b1, a[i]);
      bus(OFS_SUB_X1, 1'b1, b[i]);
      groups(2);
      check(sub_y, e[i], "sub y");
    end
    $display("test sub done");
  endtask : test_sub

  // Parity gate over all sixteen input patterns
  task automatic test_xor;
    for (int v = 0; v < 16; v++) begin
      bits_val[BIT_XOR_I0 +: 4] = 4'(v);
      bus(OFS_BITS, 1'b1, bits_val);
      groups(2);
      check(xor_q, ^(4'(v)), "xor q");
    end
    $display("test xor done");
  endtask : test_xor

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_idle();
    test_poly();
    test_pst();
    test_lag();
    test_latch();
    test_sub();
    test_xor();
    finish_test();
  end

  // Tests take about 5100 cycles; allow a wide margin before giving up
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
